//--- hdl/occ_clock_ctrl.sv
// occ_clock_ctrl: oscillator selection, strap driven pll defaults,
// reference timer and clock block 0 with port binding.
// assumes straps are pins (synchronised here) and a 25 mhz clk_i.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module occ_clock_ctrl #(
	parameter int NUM_PORTS = 8,
	parameter int CB_SEL_W  = 2
) (
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	input  wire logic [occ_pkg::ADDR_W-1:0]        bus_addr_i,
	input  wire logic [occ_pkg::DATA_W-1:0]        bus_wdata_i,
	input  wire logic                              bus_wr_i,
	input  wire logic                              bus_rd_i,
	output logic      [occ_pkg::DATA_W-1:0]        bus_rdata_o,
	input  wire logic                              osc_source_select_n_i,
	input  wire logic                              freq_range_strap_lo_i,
	input  wire logic                              freq_range_strap_hi_i,
	input  wire logic                              low_power_i,
	output logic                                   xtal_osc_en_o,
	output logic                                   rosc20_en_o,
	output logic                                   lowrate_osc_en_o,
	output logic                                   rtc_clk_lowrate_o,
	output logic                                   main_osc_ext_o,
	output occ_pkg::occ_pll_cfg_t                  pll_cfg_o,
	output logic      [occ_pkg::NUM_W-1:0]         tile_ratio_num_o,
	output logic      [occ_pkg::DEN_W-1:0]         tile_ratio_den_o,
	output logic      [occ_pkg::TIMER_W-1:0]       ref_time_o,
	input  wire logic                              clkblk_pin_i,
	output logic                                   clkblk_pin_o,
	output logic                                   clkblk_pin_oe_o,
	output logic                                   clkblk_clk_o,
	output logic      [NUM_PORTS*CB_SEL_W-1:0]     port_clkblk_o
);

	localparam int PB_W = NUM_PORTS * CB_SEL_W;
	localparam int NSYNC = 4;

	generate
		if (PB_W > occ_pkg::DATA_W || CB_SEL_W < 1 || NUM_PORTS < 1) begin : g_bad
			$error("occ_clock_ctrl: port binding does not fit one register");
		end
	endgenerate

	// ---------------------------------------------------------------
	// pin synchronisers: osc select, strap lo, strap hi, clock pin
	// ---------------------------------------------------------------
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] pin_s1_reg;
	logic [NSYNC-1:0] pin_s2_reg;

	assign pin_raw = {clkblk_pin_i, freq_range_strap_hi_i,
		freq_range_strap_lo_i, osc_source_select_n_i};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			// data-path flops: no reset, so the pin level is never masked
			always_ff @(posedge clk_i) begin
				pin_s1_reg[gi] <= pin_raw[gi];
				pin_s2_reg[gi] <= pin_s1_reg[gi];
			end
		end
	endgenerate

	logic       osc_n_s;
	logic [1:0] code_s;
	logic       ext_clk_s;

	assign osc_n_s   = pin_s2_reg[0];
	assign code_s    = pin_s2_reg[2:1];
	assign ext_clk_s = pin_s2_reg[3];

	// ---------------------------------------------------------------
	// strap capture: sampled all through reset, frozen at release
	// ---------------------------------------------------------------
	logic       ext_sel_reg;
	logic [1:0] strap_code_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_sel_reg    <= ~osc_n_s;
			strap_code_reg <= code_s;
		end
	end

	function automatic occ_pkg::occ_pll_cfg_t strap_default(input logic [1:0] code);
		occ_pkg::occ_pll_cfg_t cfg;
		cfg = occ_pkg::PLL_DEF_00;
		case (code)
			2'h0: begin
				cfg = occ_pkg::PLL_DEF_00;
			end
			2'h1: begin
				cfg = occ_pkg::PLL_DEF_01;
			end
			2'h2: begin
				cfg = occ_pkg::PLL_DEF_10;
			end
			default: begin
				cfg = occ_pkg::PLL_DEF_11;
			end
		endcase
		return cfg;
	endfunction : strap_default

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	occ_pkg::occ_pll_cfg_t   pll_cfg_reg;
	logic                    sw_cfg_reg;
	logic [CB_SEL_W-1:0]     cb_sel_dummy;
	logic                    cb_src_pin_reg;
	logic                    cb_pin_en_reg;
	logic [occ_pkg::CB_DIV_W-1:0] cb_div_reg;
	logic [PB_W-1:0]         port_cb_reg;

	logic wr_pll;
	logic wr_cb;
	logic wr_pb;

	always_comb begin
		wr_pll = 1'b0;
		wr_cb  = 1'b0;
		wr_pb  = 1'b0;
		if (bus_addr_i == occ_pkg::PLL_CFG_OFS) begin
			wr_pll = bus_wr_i;
		end else if (bus_addr_i == occ_pkg::CB_CTRL_OFS) begin
			wr_cb = bus_wr_i;
		end else if (bus_addr_i == occ_pkg::PORT_CB_OFS) begin
			wr_pb = bus_wr_i;
		end
	end

	assign cb_sel_dummy = '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_cfg_reg <= strap_default(code_s);
			sw_cfg_reg  <= 1'b0;
		end else if (wr_pll) begin
			pll_cfg_reg.fb <= bus_wdata_i[occ_pkg::F_LSB +: occ_pkg::F_W];
			pll_cfg_reg.in_div <= bus_wdata_i[occ_pkg::R_LSB +: occ_pkg::R_W];
			pll_cfg_reg.pll_output_divider <=
				bus_wdata_i[occ_pkg::OD_LSB +: occ_pkg::OD_W];
			sw_cfg_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cb_src_pin_reg <= 1'b0;
			cb_pin_en_reg  <= 1'b0;
			cb_div_reg     <= occ_pkg::CB_DIV_RST;
		end else if (wr_cb) begin
			cb_src_pin_reg <= bus_wdata_i[occ_pkg::CB_SRC_BIT];
			cb_pin_en_reg  <= bus_wdata_i[occ_pkg::CB_PINEN_BIT];
			cb_div_reg     <= bus_wdata_i[occ_pkg::CB_DIV_LSB +: occ_pkg::CB_DIV_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_cb_reg <= {NUM_PORTS{cb_sel_dummy}};
		end else if (wr_pb) begin
			port_cb_reg <= bus_wdata_i[PB_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// oscillator steering
	// ---------------------------------------------------------------
	logic xtal_en_reg;
	logic rosc_en_reg;
	logic lowr_en_reg;
	logic rtc_lowr_reg;
	logic main_ext_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xtal_en_reg  <= 1'b0;
			rosc_en_reg  <= 1'b1;
			lowr_en_reg  <= 1'b0;
			rtc_lowr_reg <= 1'b0;
			main_ext_reg <= 1'b0;
		end else begin
			xtal_en_reg  <= ext_sel_reg;
			rosc_en_reg  <= ~ext_sel_reg;
			lowr_en_reg  <= low_power_i;
			rtc_lowr_reg <= low_power_i;
			// analog node and pll reference share the selected oscillator
			main_ext_reg <= ext_sel_reg;
		end
	end

	// ---------------------------------------------------------------
	// tile ratio: num / den = (fb+1) / (2 (r+1) (od+1))
	// ---------------------------------------------------------------
	logic [occ_pkg::NUM_W-1:0] num_reg;
	logic [occ_pkg::DEN_W-1:0] den_reg;
	logic [6:0]                r_p1;
	logic [3:0]                od_p1;
	logic [10:0]               r_od;

	assign r_p1  = {1'b0, pll_cfg_reg.in_div} + 7'h01;
	assign od_p1 = {1'b0, pll_cfg_reg.pll_output_divider} + 4'h1;
	assign r_od  = 11'(r_p1 * od_p1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			num_reg <= '0;
			den_reg <= '0;
		end else begin
			num_reg <= {1'b0, pll_cfg_reg.fb} + 13'h0001;
			den_reg <= {r_od, 1'b0};
		end
	end

	// ---------------------------------------------------------------
	// reference timer: 4 ticks of 10 ns per 40 ns system cycle
	// ---------------------------------------------------------------
	logic [occ_pkg::TIMER_W-1:0] timer_val;

	occ_ref_timer #(
		.WIDTH (occ_pkg::TIMER_W),
		.STEP  (occ_pkg::TIMER_STEP)
	) u_timer (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.count_o (timer_val)
	);

	// ---------------------------------------------------------------
	// clock block 0
	// ---------------------------------------------------------------
	occ_pkg::occ_cb_src_t         cb_state_reg;
	logic [occ_pkg::CB_DIV_W-1:0] cb_cnt_reg;
	logic                         cb_clk_reg;
	logic                         cb_pin_reg;
	logic                         cb_oe_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cb_state_reg <= occ_pkg::CB_FROM_REF;
		end else begin
			case (cb_state_reg)
				occ_pkg::CB_FROM_REF: begin
					if (cb_src_pin_reg) begin
						cb_state_reg <= occ_pkg::CB_FROM_PIN;
					end
				end
				occ_pkg::CB_FROM_PIN: begin
					if (!cb_src_pin_reg) begin
						cb_state_reg <= occ_pkg::CB_FROM_REF;
					end
				end
				default: begin
					cb_state_reg <= occ_pkg::CB_FROM_REF;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cb_cnt_reg <= '0;
			cb_clk_reg <= 1'b0;
		end else if (cb_state_reg == occ_pkg::CB_FROM_PIN) begin
			cb_cnt_reg <= '0;
			cb_clk_reg <= ext_clk_s;
		end else if (cb_cnt_reg >= cb_div_reg) begin
			// a shrinking divider never strands the count above it
			cb_cnt_reg <= '0;
			cb_clk_reg <= ~cb_clk_reg;
		end else begin
			cb_cnt_reg <= cb_cnt_reg + 8'h01;
		end
	end

	// pin output is dropped while the pin is the source, to avoid a loop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cb_pin_reg <= 1'b0;
			cb_oe_reg  <= 1'b0;
		end else begin
			cb_pin_reg <= cb_clk_reg;
			cb_oe_reg  <= cb_pin_en_reg & ~cb_src_pin_reg;
		end
	end

	// ---------------------------------------------------------------
	// register reads: data in the cycle after the strobe only
	// ---------------------------------------------------------------
	logic [occ_pkg::DATA_W-1:0] rd_value;
	logic [occ_pkg::DATA_W-1:0] rdata_reg;

	always_comb begin
		rd_value = '0;
		if (bus_addr_i == occ_pkg::PLL_CFG_OFS) begin
			rd_value[occ_pkg::F_LSB +: occ_pkg::F_W]   = pll_cfg_reg.fb;
			rd_value[occ_pkg::R_LSB +: occ_pkg::R_W]   = pll_cfg_reg.in_div;
			rd_value[occ_pkg::OD_LSB +: occ_pkg::OD_W] =
				pll_cfg_reg.pll_output_divider;
		end else if (bus_addr_i == occ_pkg::STATUS_OFS) begin
			rd_value[occ_pkg::ST_EXT_BIT]         = ext_sel_reg;
			rd_value[occ_pkg::ST_CODE_LSB +: 2]   = strap_code_reg;
			rd_value[occ_pkg::ST_SWCFG_BIT]       = sw_cfg_reg;
			rd_value[occ_pkg::ST_LOWR_BIT]        = lowr_en_reg;
		end else if (bus_addr_i == occ_pkg::RATIO_OFS) begin
			rd_value[occ_pkg::NUM_LSB +: occ_pkg::NUM_W] = num_reg;
			rd_value[occ_pkg::DEN_LSB +: occ_pkg::DEN_W] = den_reg;
		end else if (bus_addr_i == occ_pkg::TIMER_OFS) begin
			rd_value = timer_val;
		end else if (bus_addr_i == occ_pkg::CB_CTRL_OFS) begin
			rd_value[occ_pkg::CB_SRC_BIT]   = cb_src_pin_reg;
			rd_value[occ_pkg::CB_PINEN_BIT] = cb_pin_en_reg;
			rd_value[occ_pkg::CB_DIV_LSB +: occ_pkg::CB_DIV_W] = cb_div_reg;
		end else if (bus_addr_i == occ_pkg::PORT_CB_OFS) begin
			rd_value[PB_W-1:0] = port_cb_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= '0;
		end else if (bus_rd_i) begin
			rdata_reg <= rd_value;
		end else begin
			rdata_reg <= '0;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign bus_rdata_o       = rdata_reg;
	assign xtal_osc_en_o     = xtal_en_reg;
	assign rosc20_en_o       = rosc_en_reg;
	assign lowrate_osc_en_o  = lowr_en_reg;
	assign rtc_clk_lowrate_o = rtc_lowr_reg;
	assign main_osc_ext_o    = main_ext_reg;
	// pll settings feed switch, tile and reference
	assign pll_cfg_o         = pll_cfg_reg;
	assign tile_ratio_num_o  = num_reg;
	assign tile_ratio_den_o  = den_reg;
	assign ref_time_o        = timer_val;
	assign clkblk_pin_o      = cb_pin_reg;
	assign clkblk_pin_oe_o   = cb_oe_reg;
	assign clkblk_clk_o      = cb_clk_reg;
	assign port_clkblk_o     = port_cb_reg;

endmodule : occ_clock_ctrl

//--- hdl/occ_pkg.sv
// occ_pkg: register map, field layout, strap defaults and timing counts
// for the oscillator / pll clock control block.
// assumes a 25 mhz system clock and a plain one-cycle register port.
package occ_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] PLL_CFG_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS  = 8'h04;
	localparam logic [7:0] RATIO_OFS   = 8'h08;
	localparam logic [7:0] TIMER_OFS   = 8'h0c;
	localparam logic [7:0] CB_CTRL_OFS = 8'h10;
	localparam logic [7:0] PORT_CB_OFS = 8'h14;

	// pll configuration fields
	localparam int F_LSB  = 0;
	localparam int F_W    = 12;
	localparam int R_LSB  = 12;
	localparam int R_W    = 6;
	localparam int OD_LSB = 18;
	localparam int OD_W   = 3;

	typedef struct packed {
		logic [OD_W-1:0] pll_output_divider;
		logic [R_W-1:0]  in_div;
		logic [F_W-1:0]  fb;
	} occ_pll_cfg_t;

	// strap code {hi, lo} defaults
	localparam occ_pll_cfg_t PLL_DEF_00 = '{3'h1, 6'h00, 12'h07a};
	localparam occ_pll_cfg_t PLL_DEF_01 = '{3'h2, 6'h00, 12'h017};
	localparam occ_pll_cfg_t PLL_DEF_10 = '{3'h2, 6'h00, 12'h031};
	localparam occ_pll_cfg_t PLL_DEF_11 = '{3'h2, 6'h00, 12'h077};

	// status bits
	localparam int ST_EXT_BIT   = 0;
	localparam int ST_CODE_LSB  = 1;
	localparam int ST_SWCFG_BIT = 3;
	localparam int ST_LOWR_BIT  = 4;

	// ratio register fields
	localparam int NUM_LSB = 0;
	localparam int NUM_W   = 13;
	localparam int DEN_LSB = 16;
	localparam int DEN_W   = 12;

	// clock block control fields
	localparam int CB_SRC_BIT   = 0;
	localparam int CB_PINEN_BIT = 1;
	localparam int CB_DIV_LSB   = 8;
	localparam int CB_DIV_W     = 8;
	localparam logic [CB_DIV_W-1:0] CB_DIV_RST = 8'h00;

	// oscillator figures
	localparam int ROSC_HZ    = 20_000_000;
	localparam int LOWRATE_HZ = 31_250;

	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int REF_TICK_NS   = 10;
	localparam int TIMER_STEP    = CLK_PERIOD_NS / REF_TICK_NS;
	localparam int TIMER_W       = 32;

	typedef enum logic [1:0] {
		CB_FROM_REF = 2'b01,
		CB_FROM_PIN = 2'b10
	} occ_cb_src_t;

endpackage : occ_pkg

//--- hdl/occ_ref_timer.sv
// occ_ref_timer: free running processor timer counting reference ticks.
// assumes one system clock spans step reference ticks.
`timescale 1ns/1ns
module occ_ref_timer #(
	parameter int WIDTH = 32,
	parameter int STEP  = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	output logic      [WIDTH-1:0] count_o
);

	localparam logic [WIDTH-1:0] STEP_V = WIDTH'(STEP);

	logic [WIDTH-1:0] count_reg;

	generate
		if (STEP < 1 || WIDTH < 2) begin : g_bad
			$error("occ_ref_timer: bad step or width");
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_reg + STEP_V;
		end
	end

	assign count_o = count_reg;

endmodule : occ_ref_timer

//--- test/occ_osc_model.sv
// occ_osc_model: board side of the clock control block, strap pins
// and a free running external clock for the clock block pin.
// assumes the bench changes strap settings only ahead of a reset.
`timescale 1ns/1ns
module occ_osc_model (
	input  wire logic       clk_i,
	input  wire logic [1:0] code_i,
	input  wire logic       ext_n_i,
	output logic            osc_source_select_n_o,
	output logic            freq_range_strap_lo_o,
	output logic            freq_range_strap_hi_o,
	output logic            ext_clk_o
);
	logic [1:0] div_reg = 2'h0;
	logic       clk_reg = 1'b0;

	assign osc_source_select_n_o = ext_n_i;
	assign freq_range_strap_lo_o = code_i[0];
	assign freq_range_strap_hi_o = code_i[1];
	assign ext_clk_o = clk_reg;

	// external clock runs free, one edge every four cycles
	always @(posedge clk_i) begin
		div_reg <= div_reg + 2'h1;
		if (div_reg == 2'h3) begin
			clk_reg <= ~clk_reg;
		end
	end
endmodule : occ_osc_model

//--- test/occ_clock_ctrl_asserts.sv
// occ_clock_ctrl_asserts: port level checks of the clock control block.
// assumes a single clock domain and a synchronous active high reset.
`timescale 1ns/1ns
module occ_clock_ctrl_asserts #(
	parameter int NUM_PORTS = 8,
	parameter int CB_SEL_W  = 2
) (
	input wire logic                          clk_i,
	input wire logic                          rst_i,
	input wire logic [occ_pkg::ADDR_W-1:0]    bus_addr_i,
	input wire logic [occ_pkg::DATA_W-1:0]    bus_wdata_i,
	input wire logic                          bus_wr_i,
	input wire logic                          bus_rd_i,
	input wire logic [occ_pkg::DATA_W-1:0]    bus_rdata_o,
	input wire logic                          low_power_i,
	input wire logic                          xtal_osc_en_o,
	input wire logic                          rosc20_en_o,
	input wire logic                          lowrate_osc_en_o,
	input wire logic                          main_osc_ext_o,
	input wire occ_pkg::occ_pll_cfg_t         pll_cfg_o,
	input wire logic [occ_pkg::NUM_W-1:0]     tile_ratio_num_o,
	input wire logic [occ_pkg::DEN_W-1:0]     tile_ratio_den_o,
	input wire logic [occ_pkg::TIMER_W-1:0]   ref_time_o,
	input wire logic [NUM_PORTS*CB_SEL_W-1:0] port_clkblk_o
);
	logic wr_cfg;
	logic rd_cfg;

	assign wr_cfg = bus_wr_i && (bus_addr_i == occ_pkg::PLL_CFG_OFS);
	assign rd_cfg = bus_rd_i && (bus_addr_i == occ_pkg::PLL_CFG_OFS);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_osc_excl: assert property (rosc20_en_o != xtal_osc_en_o)
		else $error("oscillator enables overlap");
	a_main_src: assert property (main_osc_ext_o == xtal_osc_en_o)
		else $error("main source differs from resonator enable");
	// the release edge still loads reset values, so no attempt starts on it
	a_lowrate_track: assert property (!rst_i |=> lowrate_osc_en_o == $past(low_power_i))
		else $error("low-rate enable does not follow low power");
	a_timer_step: assert property (!rst_i |=> ref_time_o == $past(ref_time_o) + 32'h4)
		else $error("timer step wrong");
	a_cfg_write: assert property (wr_cfg |=> pll_cfg_o == $past(bus_wdata_i[20:0]))
		else $error("pll write not taken");
	a_cfg_hold: assert property (!wr_cfg |=> $stable(pll_cfg_o))
		else $error("pll settings moved without a write");
	a_ratio_num: assert property (!rst_i |=> tile_ratio_num_o == $past(pll_cfg_o.fb) + 13'h1)
		else $error("ratio numerator wrong");
	a_ratio_den: assert property (!rst_i |=>
		tile_ratio_den_o == 12'(2 * ($past(pll_cfg_o.in_div) + 1)
		* ($past(pll_cfg_o.pll_output_divider) + 1)))
		else $error("ratio denominator wrong");
	a_cfg_read: assert property (rd_cfg |=> bus_rdata_o[20:0] == $past(pll_cfg_o))
		else $error("pll readback wrong");
	a_rd_idle: assert property (!bus_rd_i |=> bus_rdata_o == 32'h0)
		else $error("read data outside read cycle");
	a_port_bind: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> port_clkblk_o == '0)
		else $error("ports not on block 0 after reset");

	c_cfg_wr: cover property (wr_cfg ##2 rd_cfg);
	c_low_pwr: cover property (low_power_i ##1 lowrate_osc_en_o);
	c_timer_rd: cover property (bus_rd_i && bus_addr_i == occ_pkg::TIMER_OFS);
endmodule : occ_clock_ctrl_asserts

bind occ_clock_ctrl occ_clock_ctrl_asserts #(.NUM_PORTS(NUM_PORTS), .CB_SEL_W(CB_SEL_W))
	u_occ_clock_ctrl_asserts (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
	.bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
	.bus_rdata_o(bus_rdata_o), .low_power_i(low_power_i), .xtal_osc_en_o(xtal_osc_en_o),
	.rosc20_en_o(rosc20_en_o), .lowrate_osc_en_o(lowrate_osc_en_o),
	.main_osc_ext_o(main_osc_ext_o), .pll_cfg_o(pll_cfg_o),
	.tile_ratio_num_o(tile_ratio_num_o), .tile_ratio_den_o(tile_ratio_den_o),
	.ref_time_o(ref_time_o), .port_clkblk_o(port_clkblk_o));

//--- test/occ_clock_ctrl_tb.sv
// occ_clock_ctrl_tb: self-checking bench for the clock control block.
// assumes occ_osc_model drives the straps and the external block clock.
`timescale 1ns/1ns
module occ_clock_ctrl_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        low_power = 1'b0;
	logic [1:0]  code = 2'h0;
	logic        ext_n = 1'b0;
	logic [31:0] rdata, rv, t0;
	logic        sel_n, s_lo, s_hi, ext_clk, pin_w, pin_o, pin_oe, xtal, rosc, lowr, cbclk;
	logic        rtcl;
	logic [12:0] num;
	logic [11:0] den;
	logic [15:0] ports;
	int          fails = 0;
	int          cmp_count = 0;
	int          def_fb[4] = '{122, 23, 49, 119};
	int          def_od[4] = '{1, 2, 2, 2};
	int          cfg_q[$];
	int          f, r, o, k, t;

	always #20 clk_i = ~clk_i;
	assign pin_w = pin_oe ? pin_o : ext_clk;

	occ_osc_model u_occ_osc_model (.clk_i(clk_i), .code_i(code), .ext_n_i(ext_n),
		.osc_source_select_n_o(sel_n), .freq_range_strap_lo_o(s_lo),
		.freq_range_strap_hi_o(s_hi), .ext_clk_o(ext_clk));

	occ_clock_ctrl u_occ_clock_ctrl (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(addr),
		.bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata),
		.osc_source_select_n_i(sel_n), .freq_range_strap_lo_i(s_lo),
		.freq_range_strap_hi_i(s_hi), .low_power_i(low_power), .xtal_osc_en_o(xtal),
		.rosc20_en_o(rosc), .lowrate_osc_en_o(lowr), .rtc_clk_lowrate_o(rtcl),
		.main_osc_ext_o(), .pll_cfg_o(), .tile_ratio_num_o(num), .tile_ratio_den_o(den),
		.ref_time_o(), .clkblk_pin_i(pin_w), .clkblk_pin_o(pin_o),
		.clkblk_pin_oe_o(pin_oe), .clkblk_clk_o(cbclk), .port_clkblk_o(ports));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		if (fails == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : bus_rd

	task automatic do_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : do_reset

	// readback and ratio outputs against the model settings
	task automatic chk_cfg(input int fb, input int rd_v, input int od);
		bus_rd(occ_pkg::PLL_CFG_OFS, rv);
		chk(rv, 32'(od * 262144 + rd_v * 4096 + fb));
		chk(32'(num), 32'(fb + 1));
		chk(32'(den), 32'(2 * (rd_v + 1) * (od + 1)));
	endtask : chk_cfg

	// counts block clock edges over n cycles
	task automatic count_tog(input int n, output int c);
		logic last;
		c = 0;
		// skip the edge after the write edge, taking the baseline once the new divider applies
		@(posedge clk_i);
		#1;
		last = cbclk;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			c += (cbclk !== last);
			last = cbclk;
		end
	endtask : count_tog

	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		end_of_test();
	end

	initial begin
		rv = $urandom(6);
		for (int c = 0; c < 4; c++) begin
			@(posedge clk_i);
			code <= c[1:0];
			ext_n <= c[0];
			do_reset();
			chk_cfg(def_fb[c], 0, def_od[c]);
			bus_rd(occ_pkg::STATUS_OFS, rv);
			chk(rv & 32'h1f, {27'h0, 2'b00, code, ~ext_n});
			chk({30'h0, xtal, rosc}, {30'h0, ~ext_n, ext_n});
			chk({16'h0, ports}, 32'h0);
			bus_rd(occ_pkg::CB_CTRL_OFS, rv);
			chk(rv, 32'h0);
		end
		// software keeps the product ratio legal
		repeat (4) begin
			r = $urandom_range(63);
			k = $urandom_range(63, 13);
			cfg_q.push_back((r + 1) * k - 1);
			cfg_q.push_back(r);
			cfg_q.push_back($urandom_range(7));
		end
		while (cfg_q.size() > 0) begin
			f = cfg_q.pop_front();
			r = cfg_q.pop_front();
			o = cfg_q.pop_front();
			bus_wr(occ_pkg::PLL_CFG_OFS, 32'(o * 262144 + r * 4096 + f));
			chk_cfg(f, r, o);
		end
		bus_rd(occ_pkg::STATUS_OFS, rv);
		chk(rv & 32'h8, 32'h8);
		bus_wr(occ_pkg::RATIO_OFS, 32'hffffffff);
		bus_wr(8'h40, 32'hffffffff);
		chk_cfg(f, r, o);
		bus_rd(8'h40, rv);
		chk(rv, 32'h0);
		bus_rd(occ_pkg::TIMER_OFS, t0);
		bus_rd(occ_pkg::TIMER_OFS, rv);
		chk(rv - t0, 32'h8);
		@(posedge clk_i);
		low_power <= 1'b1;
		bus_rd(occ_pkg::STATUS_OFS, rv);
		chk(rv & 32'h10, 32'h10);
		chk({31'h0, lowr}, 32'h1);
		chk({31'h0, rtcl}, 32'h1);
		@(posedge clk_i);
		low_power <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({31'h0, lowr}, 32'h0);
		chk({31'h0, rtcl}, 32'h0);
		bus_wr(occ_pkg::CB_CTRL_OFS, 32'h00000200);
		count_tog(30, t);
		chk(32'(t), 32'd10);
		bus_wr(occ_pkg::CB_CTRL_OFS, 32'h00000003);
		repeat (4) @(posedge clk_i);
		count_tog(40, t);
		chk(32'(t), 32'd10);
		chk({31'h0, pin_oe}, 32'h0);
		bus_wr(occ_pkg::CB_CTRL_OFS, 32'h00000002);
		repeat (2) @(posedge clk_i);
		chk({31'h0, pin_oe}, 32'h1);
		bus_wr(occ_pkg::PORT_CB_OFS, 32'h0000ffff);
		bus_rd(occ_pkg::PORT_CB_OFS, rv);
		chk(rv, 32'h0000ffff);
		chk({16'h0, ports}, 32'h0000ffff);
		do_reset();
		chk_cfg(def_fb[3], 0, def_od[3]);
		chk({16'h0, ports}, 32'h0);
		end_of_test();
	end
endmodule : occ_clock_ctrl_tb
